// >>> hdl/dpr_pkg.sv
// Purpose: shared constants and types for the dual-port block RAM
// Assumes: one system clock; port pins are slow, asynchronous inputs
// Notes: storage is 512 words of 32 data bits plus 4 parity bits

package dpr_pkg;

    // array geometry
    localparam int DPR_ADDR_W = 14;
    localparam int DPR_IDX_W = 9;
    localparam int DPR_WORDS = 512;
    localparam int DPR_DATA_W = 32;
    localparam int DPR_PAR_W = 4;

    // port width codes: data width is 1 << code, parity only from code 3 up
    localparam logic [2:0] DPR_WIDTH_X1 = 3'h0;
    localparam logic [2:0] DPR_WIDTH_X9 = 3'h3;
    localparam logic [2:0] DPR_WIDTH_X36 = 3'h5;

    // output behaviour of a port during its own write cycle
    typedef enum logic [1:0] {
        DPR_WRITE_FIRST,
        DPR_READ_FIRST,
        DPR_NO_CHANGE
    } dpr_mode_type;

    // apb register byte offsets
    localparam logic [7:0] DPR_OFF_CTRL = 8'h00;
    localparam logic [7:0] DPR_OFF_INIT_A = 8'h04;
    localparam logic [7:0] DPR_OFF_SRV_A = 8'h08;
    localparam logic [7:0] DPR_OFF_PAR = 8'h0c;
    localparam logic [7:0] DPR_OFF_INIT_B = 8'h10;
    localparam logic [7:0] DPR_OFF_SRV_B = 8'h14;
    localparam logic [7:0] DPR_OFF_STATUS = 8'h18;
    localparam logic [7:0] DPR_OFF_LOAD = 8'h1c;
    localparam logic [7:0] DPR_OFF_MEM_ADDR = 8'h20;
    localparam logic [7:0] DPR_OFF_MEM_DATA = 8'h24;
    localparam logic [7:0] DPR_OFF_MEM_PAR = 8'h28;

    // control register field positions
    localparam int DPR_CTRL_WA_LSB = 0;
    localparam int DPR_CTRL_WB_LSB = 3;
    localparam int DPR_CTRL_MA_LSB = 6;
    localparam int DPR_CTRL_MB_LSB = 8;
    localparam logic [31:0] DPR_CTRL_MASK = 32'h0000_03ff;

    // values after reset
    localparam logic [31:0] DPR_CTRL_RST = 32'h0000_002d;
    localparam logic [35:0] DPR_OUT_INITIAL_A_RST = 36'h0_0000_0000;
    localparam logic [35:0] DPR_OUT_INITIAL_B_RST = 36'h0_0000_0000;
    localparam logic [35:0] DPR_OUT_RESET_A_RST = 36'h0_0000_0000;
    localparam logic [35:0] DPR_OUT_RESET_B_RST = 36'h0_0000_0000;

    // array contents after reset: each string holds 64 hex digits of data or parity
    localparam logic [255:0] DPR_DATA_PRELOAD [0:63] = '{default: 256'h0};
    localparam logic [255:0] DPR_PAR_PRELOAD [0:7] = '{default: 256'h0};

    typedef logic [35:0] dpr_word_type;

    // one port's pins as seen from the user logic
    typedef struct packed {
        logic clock;
        logic enable;
        logic write_en;
        logic sync_reset;
        logic [DPR_ADDR_W-1:0] addr;
        logic [DPR_DATA_W-1:0] wdata;
        logic [DPR_PAR_W-1:0] wpar;
    } dpr_pin_type;

    // one port request, captured at a port clock rising edge
    typedef struct packed {
        logic fire;
        logic enable;
        logic write_en;
        logic sync_reset;
        logic [DPR_ADDR_W-1:0] addr;
        logic [DPR_DATA_W-1:0] wdata;
        logic [DPR_PAR_W-1:0] wpar;
    } dpr_req_type;

endpackage : dpr_pkg

// >>> hdl/dpr_port.sv
// Purpose: bring one port's pins into the system clock and find its clock edges
// Assumes: port inputs stay stable at least three system cycles around each edge
// Notes: emits a one-cycle request pulse per rising edge of the port clock

`timescale 1ns/1ps

module dpr_port
    import dpr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire dpr_pin_type pins,
    output dpr_req_type req
);

    typedef struct packed {
        dpr_pin_type s1;
        dpr_pin_type s2;
        dpr_pin_type s3;
        logic armed;
        logic clk_level;
        dpr_req_type req;
    } dpr_port_state_type;

    dpr_port_state_type state_reg;
    dpr_port_state_type state_next;

    // three-stage chain; a level counts once stages two and three agree
    always_comb begin
        state_next = state_reg;
        state_next.req.fire = 1'b0;
        state_next.s1 = pins;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        if (state_reg.s2.clock == state_reg.s3.clock) begin
            state_next.clk_level = state_reg.s3.clock;
            state_next.armed = 1'b1; // first agreement only learns the level
            if (state_reg.armed && state_reg.s3.clock && !state_reg.clk_level) begin
                // all port traffic is keyed to its own clock edge
                state_next.req.fire = 1'b1;
                state_next.req.enable = state_reg.s3.enable;
                state_next.req.write_en = state_reg.s3.write_en;
                state_next.req.sync_reset = state_reg.s3.sync_reset;
                state_next.req.addr = state_reg.s3.addr;
                state_next.req.wdata = state_reg.s3.wdata;
                state_next.req.wpar = state_reg.s3.wpar;
            end
        end
    end

    // reset wins over the clock enable so the chain always starts clean
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign req = state_reg.req;

endmodule : dpr_port

// >>> hdl/dpr_top.sv
// Purpose: dual-port block RAM with per-port width, output register and modes
// Assumes: port pins are slow and asynchronous; software reaches setup over APB
// Notes: port clocks are sampled, not used as clocks; see the port module

`timescale 1ns/1ps

module dpr_top
    import dpr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_a_clock,
    input wire logic port_a_enable,
    input wire logic port_a_write_en,
    input wire logic port_a_sync_reset,
    input wire logic [13:0] port_a_addr,
    input wire logic [31:0] port_a_wdata,
    input wire logic [3:0] port_a_wpar,
    output logic [31:0] port_a_rdata,
    output logic [3:0] port_a_rpar,
    input wire logic port_b_clock,
    input wire logic port_b_enable,
    input wire logic port_b_write_en,
    input wire logic port_b_sync_reset,
    input wire logic [13:0] port_b_addr,
    input wire logic [31:0] port_b_wdata,
    input wire logic [3:0] port_b_wpar,
    output logic [31:0] port_b_rdata,
    output logic [3:0] port_b_rpar
);

    typedef struct packed {
        dpr_word_type [DPR_WORDS-1:0] mem;
        dpr_word_type [1:0] dout;
        dpr_word_type [1:0] out_initial;
        dpr_word_type [1:0] out_reset_value;
        logic [31:0] ctrl;
        logic [1:0][15:0] count;
        logic [DPR_IDX_W-1:0] mem_addr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dpr_top_state_type;

    dpr_top_state_type state_reg;
    dpr_top_state_type state_next;
    dpr_pin_type [1:0] port_pins;
    dpr_req_type [1:0] port_req;

    // clamp an out-of-range code to the widest port
    function automatic logic [2:0] width_code(input logic [2:0] raw);
        width_code = (raw > DPR_WIDTH_X36) ? DPR_WIDTH_X36 : raw;
    endfunction : width_code

    // word index: narrow ports use more address lines, 14 minus the code
    function automatic logic [DPR_IDX_W-1:0] word_index(input logic [13:0] addr,
                                                       input logic [2:0] code);
        logic [13:0] shifted;
        shifted = addr >> (DPR_WIDTH_X36 - code);
        word_index = shifted[DPR_IDX_W-1:0];
    endfunction : word_index

    // lane number of the narrow word inside the 32-bit word
    function automatic logic [4:0] lane_of(input logic [13:0] addr,
                                           input logic [2:0] code);
        logic [4:0] sel;
        sel = 5'h1f >> code;
        lane_of = addr[4:0] & sel;
    endfunction : lane_of

    // low-order ones as wide as the port's data path
    function automatic logic [31:0] data_mask(input logic [2:0] code);
        logic [5:0] bits;
        bits = 6'h01 << code;
        data_mask = (code == DPR_WIDTH_X36) ? 32'hffff_ffff : ((32'h1 << bits) - 32'h1);
    endfunction : data_mask

    // parity mask: one parity bit per data byte, none below x9
    function automatic logic [3:0] par_mask(input logic [2:0] code);
        logic [2:0] pbits;
        pbits = (code < DPR_WIDTH_X9) ? 3'h0 : (3'h1 << (code - DPR_WIDTH_X9));
        par_mask = (4'h1 << pbits) - 4'h1;
    endfunction : par_mask

    // extract a narrow word and its parity from a stored word
    function automatic dpr_word_type lane_read(input dpr_word_type word,
                                               input logic [13:0] addr,
                                               input logic [2:0] code);
        logic [4:0] lane;
        logic [31:0] dpart;
        logic [3:0] ppart;
        lane = lane_of(addr, code);
        dpart = (word[31:0] >> (lane << code)) & data_mask(code);
        ppart = (word[35:32] >> (lane << (code - DPR_WIDTH_X9))) & par_mask(code);
        lane_read = {ppart, dpart};
    endfunction : lane_read

    // merge a narrow word into a stored word, parity by byte lane
    function automatic dpr_word_type lane_write(input dpr_word_type word,
                                                input logic [13:0] addr,
                                                input logic [2:0] code,
                                                input logic [31:0] wdata,
                                                input logic [3:0] wpar);
        logic [4:0] lane;
        logic [4:0] doff;
        logic [1:0] poff;
        logic [31:0] dm;
        logic [3:0] pm;
        lane = lane_of(addr, code);
        doff = lane << code;
        poff = 2'(lane << (code - DPR_WIDTH_X9));
        dm = data_mask(code) << doff;
        pm = par_mask(code) << poff;
        lane_write[31:0] = (word[31:0] & ~dm) | ((wdata << doff) & dm);
        lane_write[35:32] = (word[35:32] & ~pm) | ((wpar << poff) & pm);
    endfunction : lane_write

    // pack the raw pins; each port gets its own sampler
    assign port_pins[0] = {port_a_clock, port_a_enable, port_a_write_en,
                           port_a_sync_reset, port_a_addr, port_a_wdata, port_a_wpar};
    assign port_pins[1] = {port_b_clock, port_b_enable, port_b_write_en,
                           port_b_sync_reset, port_b_addr, port_b_wdata, port_b_wpar};

    dpr_port u_port_a (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .pins(port_pins[0]),
        .req(port_req[0])
    );

    dpr_port u_port_b (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .pins(port_pins[1]),
        .req(port_req[1])
    );

    // next state: apb slave first, then port a, then port b
    always_comb begin
        logic [2:0] code;
        logic [1:0] mode_raw;
        logic [DPR_IDX_W-1:0] idx;
        dpr_word_type old_word;
        dpr_word_type new_word;
        logic access;
        logic hit;
        logic [31:0] rd;
        code = DPR_WIDTH_X36;
        mode_raw = 2'h0;
        idx = '0;
        old_word = '0;
        new_word = '0;
        rd = 32'h0;
        hit = 1'b1;
        access = 1'b0;
        state_next = state_reg;

        // register read mux and address decode; misaligned is unmapped
        case (paddr)
            DPR_OFF_CTRL: rd = state_reg.ctrl;
            DPR_OFF_INIT_A: rd = state_reg.out_initial[0][31:0];
            DPR_OFF_SRV_A: rd = state_reg.out_reset_value[0][31:0];
            DPR_OFF_PAR: rd = {16'h0, state_reg.out_reset_value[1][35:32],
                               state_reg.out_initial[1][35:32],
                               state_reg.out_reset_value[0][35:32],
                               state_reg.out_initial[0][35:32]};
            DPR_OFF_INIT_B: rd = state_reg.out_initial[1][31:0];
            DPR_OFF_SRV_B: rd = state_reg.out_reset_value[1][31:0];
            DPR_OFF_STATUS: rd = {state_reg.count[1], state_reg.count[0]};
            DPR_OFF_LOAD: rd = 32'h0;
            DPR_OFF_MEM_ADDR: rd = {23'h0, state_reg.mem_addr};
            DPR_OFF_MEM_DATA: rd = state_reg.mem[state_reg.mem_addr][31:0];
            DPR_OFF_MEM_PAR: rd = {28'h0, state_reg.mem[state_reg.mem_addr][35:32]};
            default: hit = 1'b0;
        endcase

        // one wait state: pready rises on the second access cycle
        access = psel && penable && !state_reg.pready;
        state_next.pready = access;
        state_next.pslverr = access && !hit;
        if (access) begin
            state_next.prdata = (hit && !pwrite) ? rd : 32'h0;
        end

        // writes land on the edge that samples pready high
        if (psel && penable && state_reg.pready && pwrite && hit) begin
            case (paddr)
                DPR_OFF_CTRL: state_next.ctrl = pwdata & DPR_CTRL_MASK;
                DPR_OFF_INIT_A: state_next.out_initial[0][31:0] = pwdata;
                DPR_OFF_SRV_A: state_next.out_reset_value[0][31:0] = pwdata;
                DPR_OFF_PAR: begin
                    state_next.out_initial[0][35:32] = pwdata[3:0];
                    state_next.out_reset_value[0][35:32] = pwdata[7:4];
                    state_next.out_initial[1][35:32] = pwdata[11:8];
                    state_next.out_reset_value[1][35:32] = pwdata[15:12];
                end
                DPR_OFF_INIT_B: state_next.out_initial[1][31:0] = pwdata;
                DPR_OFF_SRV_B: state_next.out_reset_value[1][31:0] = pwdata;
                DPR_OFF_LOAD: begin
                    // acts like the global set/reset: outputs take initial values
                    state_next.dout = state_reg.out_initial;
                end
                DPR_OFF_MEM_ADDR: state_next.mem_addr = pwdata[DPR_IDX_W-1:0];
                DPR_OFF_MEM_DATA: begin
                    state_next.mem[state_reg.mem_addr][31:0] = pwdata;
                end
                DPR_OFF_MEM_PAR: begin
                    state_next.mem[state_reg.mem_addr][35:32] = pwdata[3:0];
                end
                default: state_next.ctrl = state_reg.ctrl;
            endcase
        end

        // port operations; reads use the array as it stood before this edge
        for (int p = 0; p < 2; p++) begin
            code = width_code((p == 0) ? state_reg.ctrl[DPR_CTRL_WA_LSB +: 3]
                                       : state_reg.ctrl[DPR_CTRL_WB_LSB +: 3]);
            mode_raw = (p == 0) ? state_reg.ctrl[DPR_CTRL_MA_LSB +: 2]
                                : state_reg.ctrl[DPR_CTRL_MB_LSB +: 2];
            if (port_req[p].fire && port_req[p].enable) begin
                idx = word_index(port_req[p].addr, code);
                old_word = state_reg.mem[idx];
                new_word = lane_write(old_word, port_req[p].addr, code,
                                      port_req[p].wdata, port_req[p].wpar);
                state_next.count[p] = state_reg.count[p] + 16'h1;
                if (port_req[p].write_en) begin
                    // merge over pending writes so both ports can hit one word
                    state_next.mem[idx] = lane_write(state_next.mem[idx],
                                                     port_req[p].addr, code,
                                                     port_req[p].wdata,
                                                     port_req[p].wpar);
                end
                if (port_req[p].sync_reset) begin
                    state_next.dout[p] = state_reg.out_reset_value[p]
                                         & {par_mask(code), data_mask(code)};
                end else if (!port_req[p].write_en) begin
                    state_next.dout[p] = lane_read(old_word, port_req[p].addr, code);
                end else begin
                    case (dpr_mode_type'(mode_raw))
                        DPR_WRITE_FIRST: begin
                            state_next.dout[p] = lane_read(new_word,
                                                           port_req[p].addr, code);
                        end
                        DPR_READ_FIRST: begin
                            state_next.dout[p] = lane_read(old_word,
                                                           port_req[p].addr, code);
                        end
                        DPR_NO_CHANGE: state_next.dout[p] = state_reg.dout[p];
                        default: begin
                            state_next.dout[p] = lane_read(new_word,
                                                           port_req[p].addr, code);
                        end
                    endcase
                end
            end
        end

        // reset preloads the array from the strings and outputs from initials
        if (rst) begin
            for (int i = 0; i < DPR_WORDS; i++) begin
                state_next.mem[i][31:0] = DPR_DATA_PRELOAD[i / 8][(i % 8) * 32 +: 32];
                state_next.mem[i][35:32] = DPR_PAR_PRELOAD[i / 64][(i % 64) * 4 +: 4];
            end
            state_next.out_initial[0] = DPR_OUT_INITIAL_A_RST;
            state_next.out_initial[1] = DPR_OUT_INITIAL_B_RST;
            state_next.out_reset_value[0] = DPR_OUT_RESET_A_RST;
            state_next.out_reset_value[1] = DPR_OUT_RESET_B_RST;
            state_next.dout[0] = DPR_OUT_INITIAL_A_RST;
            state_next.dout[1] = DPR_OUT_INITIAL_B_RST;
            state_next.ctrl = DPR_CTRL_RST;
            state_next.count = '0;
            state_next.mem_addr = '0;
            state_next.prdata = 32'h0;
            state_next.pready = 1'b0;
            state_next.pslverr = 1'b0;
        end
    end

    // reset is honoured even with the clock enable low; otherwise all freezes
    always_ff @(posedge ref_clk) begin
        if (rst || clk_en) begin
            state_reg <= state_next;
        end
    end

    // every output comes straight from the state register
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign port_a_rdata = state_reg.dout[0][31:0];
    assign port_a_rpar = state_reg.dout[0][35:32];
    assign port_b_rdata = state_reg.dout[1][31:0];
    assign port_b_rpar = state_reg.dout[1][35:32];

endmodule : dpr_top

// >>> tb/dpr_top_asserts.sv
// Purpose: concurrent checks on the block ram bus and port outputs
// Assumes: port clocks are sampled pins whose effects land a few cycles later
// Notes: bound to dpr_top from the bench top file
`timescale 1ns/1ps
module dpr_top_asserts
    import dpr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic port_a_clock,
    input wire logic [31:0] port_a_rdata,
    input wire logic [3:0] port_a_rpar,
    input wire logic port_b_clock,
    input wire logic [31:0] port_b_rdata,
    input wire logic [3:0] port_b_rpar
);
    logic [4:0] age_a_reg, age_b_reg;
    logic prev_a_reg, prev_b_reg;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // cycles since each port clock pin rose, saturating so it never wraps
    always_ff @(posedge ref_clk) begin
        prev_a_reg <= port_a_clock;
        prev_b_reg <= port_b_clock;
        if (rst) begin
            age_a_reg <= 5'h1f;
            age_b_reg <= 5'h1f;
        end else begin
            age_a_reg <= (port_a_clock && !prev_a_reg) ? 5'h0
                         : age_a_reg + {4'h0, age_a_reg != 5'h1f};
            age_b_reg <= (port_b_clock && !prev_b_reg) ? 5'h0
                         : age_b_reg + {4'h0, age_b_reg != 5'h1f};
        end
    end
    a_ready_late: assert property (psel && penable && $past(psel && !penable) |=> pready)
        else $error("pready late after access start");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_setup_quiet: assert property (!(psel && penable) |-> !pready)
        else $error("pready outside access phase");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    a_rst_apb: assert property ($fell(rst) |-> !pready && prdata == 32'h0)
        else $error("bus outputs not cleared by reset");
    a_out_initial: assert property ($fell(rst) |->
        {port_a_rpar, port_a_rdata} == DPR_OUT_INITIAL_A_RST
        && {port_b_rpar, port_b_rdata} == DPR_OUT_INITIAL_B_RST)
        else $error("outputs not at initial value after reset");
    a_hold_a: assert property ($changed({port_a_rpar, port_a_rdata}) |->
        age_a_reg inside {[2:8]} || $past(psel && penable && pready && pwrite))
        else $error("port a output moved without a port a edge");
    a_hold_b: assert property ($changed({port_b_rpar, port_b_rdata}) |->
        age_b_reg inside {[2:8]} || $past(psel && penable && pready && pwrite))
        else $error("port b output moved without a port b edge");
endmodule : dpr_top_asserts

// >>> tb/dpr_user.sv
// Purpose: user logic on one ram port, driving its pins
// Assumes: inputs must settle one cycle before and hold four after a rise
// Notes: released address and data lines show inverted values so stale data is never seen
`timescale 1ns/1ps
module dpr_user
    import dpr_pkg::*;
(
    input wire logic ref_clk,
    output dpr_pin_type pins
);
    initial begin
        pins = '0;
    end
    // ctl is {sync_reset, write_en, enable}; clock high four and low four
    task automatic op(input logic [2:0] ctl, input logic [13:0] a,
                      input logic [31:0] d, input logic [3:0] p);
        @(posedge ref_clk);
        pins.enable <= ctl[0];
        pins.write_en <= ctl[1];
        pins.sync_reset <= ctl[2];
        pins.addr <= a;
        pins.wdata <= d;
        pins.wpar <= p;
        @(posedge ref_clk);
        pins.clock <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pins.clock <= 1'b0;
        pins.enable <= 1'b0; // other port output not used meanwhile
        pins.write_en <= 1'b0;
        pins.sync_reset <= 1'b0;
        pins.addr <= ~a;
        pins.wdata <= ~d;
        pins.wpar <= ~p;
        repeat (4) @(posedge ref_clk);
    endtask : op
endmodule : dpr_user

// >>> tb/tb_dpr_top.sv
// Purpose: directed bench for the dual-port block ram
// Assumes: apb for setup, both ports driven by user-logic models
// Notes: expected words worked out by hand from the lane layout
`timescale 1ns/1ps
module tb_dpr_top;
    import dpr_pkg::*;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, a_d, b_d;
    logic [3:0] a_p, b_p;
    dpr_pin_type pa, pb;
    int mismatches, n_checks;
    dpr_user ua (.ref_clk(ref_clk), .pins(pa));
    dpr_user ub (.ref_clk(ref_clk), .pins(pb));
    dpr_top i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_a_clock(pa.clock), .port_a_enable(pa.enable), .port_a_write_en(pa.write_en),
        .port_a_sync_reset(pa.sync_reset), .port_a_addr(pa.addr), .port_a_wdata(pa.wdata),
        .port_a_wpar(pa.wpar), .port_a_rdata(a_d), .port_a_rpar(a_p),
        .port_b_clock(pb.clock), .port_b_enable(pb.enable), .port_b_write_en(pb.write_en),
        .port_b_sync_reset(pb.sync_reset), .port_b_addr(pb.addr), .port_b_wdata(pb.wdata),
        .port_b_wpar(pb.wpar), .port_b_rdata(b_d), .port_b_rpar(b_p));
    // clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        close_out();
    end
    task automatic close_out();
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // one apb transfer; waits for pready with no assumed latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        apb(1'b0, DPR_OFF_CTRL, 32'h0);
        chk("ctrl", {4'h0, rd}, {4'h0, DPR_CTRL_RST});
        apb(1'b0, DPR_OFF_MEM_DATA, 32'h0);
        chk("preload", {4'h0, rd}, {4'h0, DPR_DATA_PRELOAD[0][31:0]});
        apb(1'b0, DPR_OFF_MEM_PAR, 32'h0);
        chk("preload_p", {4'h0, rd}, {32'h0, DPR_PAR_PRELOAD[0][3:0]});
        chk("a_init", {a_p, a_d}, DPR_OUT_INITIAL_A_RST);
        ua.op(3'b011, 14'h3, 32'h1234_5678, 4'ha);
        chk("a_wfirst", {a_p, a_d}, 36'ha_1234_5678);
        ub.op(3'b001, 14'h3, 32'h0, 4'h0);
        chk("b_read", {b_p, b_d}, 36'ha_1234_5678);
        ua.op(3'b010, 14'h3, 32'hdead_beef, 4'h1);
        chk("a_off", {a_p, a_d}, 36'ha_1234_5678);
        ub.op(3'b001, 14'h3, 32'h0, 4'h0);
        chk("b_off", {b_p, b_d}, 36'ha_1234_5678);
        apb(1'b1, DPR_OFF_CTRL, 32'h6d);
        ua.op(3'b011, 14'h3, 32'h0bad_f00d, 4'h5);
        chk("a_rfirst", {a_p, a_d}, 36'ha_1234_5678);
        apb(1'b1, DPR_OFF_CTRL, 32'had);
        ua.op(3'b011, 14'h3, 32'h8877_6655, 4'h9);
        chk("a_nochg", {a_p, a_d}, 36'ha_1234_5678);
        ub.op(3'b001, 14'h3, 32'h0, 4'h0);
        chk("b_nochg", {b_p, b_d}, 36'h9_8877_6655);
        apb(1'b1, DPR_OFF_CTRL, 32'h2d);
        apb(1'b1, DPR_OFF_SRV_A, 32'hcafe_0001);
        apb(1'b1, DPR_OFF_PAR, 32'h50);
        ua.op(3'b111, 14'h4, 32'h4444_4444, 4'h4);
        chk("a_srst", {a_p, a_d}, 36'h5_cafe_0001);
        ub.op(3'b001, 14'h4, 32'h0, 4'h0);
        chk("b_srst", {b_p, b_d}, 36'h4_4444_4444);
        apb(1'b0, DPR_OFF_SRV_A, 32'h0);
        chk("srv_a", {4'h0, rd}, 36'h0_cafe_0001);
        apb(1'b1, DPR_OFF_CTRL, 32'h1d);
        ub.op(3'b001, 14'hf, 32'h0, 4'h0);
        chk("b_x9", {b_p, b_d}, 36'h1_0000_0088);
        ub.op(3'b011, 14'h10, 32'hab, 4'h1);
        chk("b_x9w", {b_p, b_d}, 36'h1_0000_00ab);
        ua.op(3'b001, 14'h4, 32'h0, 4'h0);
        chk("a_merge", {a_p, a_d}, 36'h5_4444_44ab);
        apb(1'b1, DPR_OFF_CTRL, 32'h25);
        ub.op(3'b001, 14'h9, 32'h0, 4'h0);
        chk("b_x18", {b_p, b_d}, 36'h1_0000_4444);
        apb(1'b1, DPR_OFF_CTRL, 32'h15);
        ub.op(3'b001, 14'h1f, 32'h0, 4'h0);
        chk("b_x4", {b_p, b_d}, 36'h0_0000_0008);
        apb(1'b1, DPR_OFF_INIT_A, 32'h1111_2222);
        apb(1'b1, DPR_OFF_PAR, 32'h56);
        apb(1'b1, DPR_OFF_LOAD, 32'h0);
        @(posedge ref_clk); // the load lands on the edge that ends the transfer
        chk("a_load", {a_p, a_d}, 36'h6_1111_2222);
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, i ? 8'h40 : 8'h02, 32'h0);
            chk("bad_addr", {3'h0, err, rd}, 36'h1_0000_0000);
        end
        close_out();
    end
endmodule : tb_dpr_top
bind dpr_top dpr_top_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_clock(port_a_clock), .port_a_rdata(port_a_rdata),
    .port_a_rpar(port_a_rpar), .port_b_clock(port_b_clock),
    .port_b_rdata(port_b_rdata), .port_b_rpar(port_b_rpar));
